// file: core/ubsg_pkg.sv
// constants, register map and types of the break/status/baud block
package ubsg_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_STATUS2 = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_RATE = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN = 8'h14;
	localparam int ADDR_LSB_W = 8;

	// second status register fields
	localparam int ST2_RXACT_BIT = 0;
	localparam int ST2_BREAK_BIT = 1;

	// bit rate select register fields
	localparam int RATE_RSEL_LSB = 0;
	localparam int RATE_PSEL_LSB = 4;
	localparam int RATE_CKS_BIT = 6;
	localparam logic [7:0] RATE_RESET = 8'h00;

	// interrupt status/enable/clear layout
	localparam int IRQ_W = 3;
	localparam int IRQ_RXFULL_BIT = 0;
	localparam int IRQ_FRAME_BIT = 1;
	localparam int IRQ_IDLE_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

	// prescaler divisors per code, stored as terminal count (divisor - 1)
	localparam logic [3:0] PD_TC_00 = 4'h0;
	localparam logic [3:0] PD_TC_01 = 4'h2;
	localparam logic [3:0] PD_TC_10 = 4'h3;
	localparam logic [3:0] PD_TC_11 = 4'hc;
	localparam logic [6:0] BD_ONE = 7'h01;

	// receiver sample slots: 16 per bit, index 0 is the first slot
	localparam logic [3:0] SLOT_FIRST = 4'h0;
	localparam logic [3:0] SLOT_SECOND = 4'h1;
	localparam logic [3:0] SLOT_MID = 4'h7;
	localparam logic [3:0] SLOT_LAST = 4'hf;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	// idle character: ten bit times of ones, counted in sample ticks
	localparam logic [7:0] IDLE_TICKS = 8'ha0;

	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} ubsg_rx_state_e;
endpackage

// file: core/ubsg_baud_if.sv
// rate settings to the generator and the sample tick back
`timescale 1ns/1ps
interface ubsg_baud_if;
	logic rate_clock_source_select;
	logic [1:0] psel;
	logic [2:0] rsel;
	logic tick16;
	modport cfg (output rate_clock_source_select, output psel, output rsel, input tick16);
	modport gen (input rate_clock_source_select, input psel, input rsel, output tick16);
endinterface

// file: core/ubsg_baud_gen.sv
// baud generator: source select, prescaler and binary divisor
`timescale 1ns/1ps
module ubsg_baud_gen
	import ubsg_pkg::*;
(
	input wire logic clk_i, // bus clock
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic xtal_tick_i, // one pulse per crystal reference period
	ubsg_baud_if.gen bif // settings in, sample tick out
);
	logic src_tick;
	logic [3:0] pre_cnt;
	logic [3:0] pre_tc;
	logic pre_tick;
	logic [6:0] div_cnt;
	logic [6:0] div_tc;

	// source clock: bus clock every cycle, else the crystal pulse
	assign src_tick = bif.rate_clock_source_select ? 1'b1 : xtal_tick_i;

	// prescaler terminal count per code
	always_comb begin
		unique case (bif.psel)
			2'b00: pre_tc = PD_TC_00;
			2'b01: pre_tc = PD_TC_01;
			2'b10: pre_tc = PD_TC_10;
			2'b11: pre_tc = PD_TC_11;
		endcase
	end

	// divisor is two to the code, so terminal count is that minus one
	assign div_tc = 7'((BD_ONE << bif.rsel) - BD_ONE);

	assign pre_tick = src_tick && (pre_cnt >= pre_tc);

	// prescaler counter; >= keeps it sane if the code shrinks mid-count
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pre_cnt <= 4'h0;
		end else if (pre_tick) begin
			pre_cnt <= 4'h0;
		end else if (src_tick) begin
			pre_cnt <= pre_cnt + 4'h1;
		end
	end

	// rate divisor counter, output is the 16x sample tick
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_cnt <= 7'h00;
			bif.tick16 <= 1'b0;
		end else begin
			bif.tick16 <= 1'b0;
			if (pre_tick) begin
				if (div_cnt >= div_tc) begin
					div_cnt <= 7'h00;
					bif.tick16 <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 7'h01;
				end
			end
		end
	end
endmodule

// file: core/ubsg_top.sv
// break/activity status, data buffer and baud rate block on AHB-Lite
`timescale 1ns/1ps
// Behaviour
// - break character sets break flag
// - break also flags framing error, full, clears ninth
// - break flag raises no interrupt
// - clear: read status with flag, then data
// - rearm only after line high, new break
// - reset clears break flag
// - low in first slot sets reception flag
// - false start or idle clears reception flag
// - data read gives rx byte, write loads tx
// - reset leaves data buffer untouched
// - source select: one bus clock, zero crystal
// - prescaler codes give 1, 3, 4, 13
// - rate divisor is two to the code
// - rate is source over 16*PD*BD
// - reset clears prescaler and divisor fields
// - one rate times receiver and transmitter
module ubsg_top
	import ubsg_pkg::*;
(
	input wire logic clk_i, // bus clock, 10 MHz
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic hsel_i, // slave select
	input wire logic [31:0] haddr_i, // byte address
	input wire logic [1:0] htrans_i, // transfer type
	input wire logic hwrite_i, // write when high
	input wire logic [2:0] hsize_i, // transfer size, words only
	input wire logic [31:0] hwdata_i, // write data
	input wire logic hready_i, // bus ready
	output logic [31:0] hrdata_o, // read data
	output logic hreadyout_o, // slave ready
	output logic hresp_o, // always okay
	input wire logic rxd_i, // serial receive line
	input wire logic xtal_tick_i, // crystal reference pulse
	input wire logic nine_bit_i, // 9-bit character mode
	output logic tick16_o, // shared 16x sample tick for the transmitter
	output logic [7:0] tx_data_o, // byte to transmit
	output logic tx_load_o, // pulse: new transmit byte written
	output logic rx_full_set_o, // pulse: character into buffer
	output logic frame_err_set_o, // pulse: stop bit read as zero
	output logic rx_bit8_o, // received ninth bit
	output logic data_read_o, // pulse: data buffer read
	output logic irq_o // level interrupt
);
	ubsg_baud_if bif ();

	logic [7:0] rate;
	logic [7:0] rx_data;
	logic [7:0] tx_data;
	logic rx_bit8;
	logic brk_flag;
	logic brk_clr_armed;
	logic brk_armed;
	logic rx_active;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_set;

	logic ap_valid;
	logic dp_write;
	logic dp_read;
	logic rd_done;
	logic [7:0] dp_addr;
	logic wr_en;
	logic rd_en;
	logic [31:0] rd_mux;

	ubsg_rx_state_e rx_state;
	logic [3:0] slot;
	logic [3:0] bit_cnt;
	logic [8:0] shreg;
	logic [7:0] ones_cnt;
	logic idle_armed;
	logic tick;
	logic mid;
	logic last;
	logic [3:0] nbits;
	logic char_done;
	logic stop_low;
	logic data_zero;
	logic is_break;
	logic false_start;
	logic idle_hit;

	// baud generator shared by both directions
	ubsg_baud_gen u_baud (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.xtal_tick_i(xtal_tick_i),
		.bif(bif)
	);

	// rate fields drive the generator directly
	assign bif.rate_clock_source_select = rate[RATE_CKS_BIT];
	assign bif.psel = rate[RATE_PSEL_LSB +: 2];
	assign bif.rsel = rate[RATE_RSEL_LSB +: 3];
	assign tick = bif.tick16;
	assign tick16_o = bif.tick16;

	// bus handshake: reads take one wait state so that a read right
	// after a write sees the freshly written value
	assign ap_valid = hsel_i && htrans_i[1] && hready_i;
	assign hreadyout_o = !(dp_read && !rd_done);
	assign hresp_o = 1'b0;
	assign wr_en = dp_write && hready_i;
	assign rd_en = dp_read && !rd_done;

	// address phase capture
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			rd_done <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready_i) begin
			dp_write <= ap_valid && hwrite_i;
			dp_read <= ap_valid && !hwrite_i;
			rd_done <= 1'b0;
			dp_addr <= haddr_i[ADDR_LSB_W-1:0];
		end else if (rd_en) begin
			rd_done <= 1'b1;
		end
	end

	// read mux; unmapped and write-only addresses read as zero
	always_comb begin
		rd_mux = WORD_ZERO;
		unique case (dp_addr)
			OFS_STATUS2: begin
				rd_mux[ST2_BREAK_BIT] = brk_flag;
				rd_mux[ST2_RXACT_BIT] = rx_active;
			end
			OFS_DATA: rd_mux[7:0] = rx_data;
			OFS_RATE: rd_mux[7:0] = rate;
			OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
			OFS_IRQ_EN: rd_mux[IRQ_W-1:0] = irq_en;
			default: rd_mux = WORD_ZERO;
		endcase
	end

	// read data register, held until the next read
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			hrdata_o <= WORD_ZERO;
		end else if (rd_en) begin
			hrdata_o <= rd_mux;
		end
	end

	// bit rate select register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rate <= RATE_RESET;
		end else if (wr_en && dp_addr == OFS_RATE) begin
			// only the three fields hold data; the spare bits stay zero
			rate[RATE_CKS_BIT] <= hwdata_i[RATE_CKS_BIT];
			rate[RATE_PSEL_LSB +: 2] <= hwdata_i[RATE_PSEL_LSB +: 2];
			rate[RATE_RSEL_LSB +: 3] <= hwdata_i[RATE_RSEL_LSB +: 3];
		end
	end

	// transmit half of the data buffer; no reset, contents survive it
	always_ff @(posedge clk_i) begin
		if (wr_en && dp_addr == OFS_DATA) begin
			tx_data <= hwdata_i[7:0];
		end
	end
	assign tx_data_o = tx_data;

	// write and read strobes toward the rest of the unit
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			tx_load_o <= 1'b0;
			data_read_o <= 1'b0;
		end else begin
			tx_load_o <= wr_en && dp_addr == OFS_DATA;
			data_read_o <= rd_en && dp_addr == OFS_DATA;
		end
	end

	// receiver slot decode
	assign mid = tick && slot == SLOT_MID;
	assign last = tick && slot == SLOT_LAST;
	assign nbits = nine_bit_i ? BITS_9 : BITS_8;
	assign char_done = rx_state == RX_STOP && mid;
	assign stop_low = !rxd_i;
	assign data_zero = nine_bit_i ? (shreg == 9'h000) : (shreg[8:1] == 8'h00);
	assign is_break = char_done && stop_low && data_zero;
	assign false_start = rx_state == RX_START && mid && rxd_i;
	assign idle_hit = rx_state == RX_IDLE && tick && rxd_i && ones_cnt == IDLE_TICKS - 8'h01;

	// receive state machine and slot counter
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rx_state <= RX_IDLE;
			slot <= SLOT_FIRST;
			bit_cnt <= 4'h0;
		end else if (tick) begin
			unique case (rx_state)
				RX_IDLE: begin
					// the search tick is the first slot of the start bit
					if (!rxd_i) begin
						rx_state <= RX_START;
						slot <= SLOT_SECOND;
					end
				end
				RX_START: begin
					slot <= slot + 4'h1;
					if (false_start) begin
						rx_state <= RX_IDLE;
					end else if (slot == SLOT_LAST) begin
						rx_state <= RX_DATA;
						bit_cnt <= 4'h0;
					end
				end
				RX_DATA: begin
					slot <= slot + 4'h1;
					if (last) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == nbits - 4'h1) begin
							rx_state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					// leave at mid stop bit so the next start is not missed
					slot <= slot + 4'h1;
					if (mid) begin
						rx_state <= RX_IDLE;
						slot <= SLOT_FIRST;
					end
				end
			endcase
		end
	end

	// shift register, LSB first, sampled at mid bit
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			shreg <= 9'h000;
		end else if (rx_state == RX_DATA && mid) begin
			shreg <= {rxd_i, shreg[8:1]};
		end
	end

	// receive half of the data buffer and ninth bit; no reset
	always_ff @(posedge clk_i) begin
		if (char_done) begin
			if (nine_bit_i) begin
				rx_data <= shreg[7:0];
				rx_bit8 <= is_break ? 1'b0 : shreg[8];
			end else begin
				rx_data <= shreg[8:1];
				rx_bit8 <= shreg[8];
			end
		end
	end
	assign rx_bit8_o = rx_bit8;

	// flag pulses to the first status register logic
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rx_full_set_o <= 1'b0;
			frame_err_set_o <= 1'b0;
		end else begin
			rx_full_set_o <= char_done;
			frame_err_set_o <= char_done && stop_low;
		end
	end

	// reception in progress flag; polled only, never interrupts
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rx_active <= 1'b0;
		end else if (rx_state == RX_IDLE && tick && !rxd_i) begin
			rx_active <= 1'b1;
		end else if (false_start || idle_hit) begin
			rx_active <= 1'b0;
		end
	end

	// idle line counter; idle only reported after a character
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ones_cnt <= 8'h00;
			idle_armed <= 1'b0;
		end else begin
			if (rx_state != RX_IDLE || (tick && !rxd_i)) begin
				ones_cnt <= 8'h00;
			end else if (tick && ones_cnt != IDLE_TICKS) begin
				ones_cnt <= ones_cnt + 8'h01;
			end
			if (char_done) begin
				idle_armed <= 1'b1;
			end else if (idle_hit) begin
				idle_armed <= 1'b0;
			end
		end
	end

	// break rearm: line must be seen high before another break counts
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			brk_armed <= 1'b1;
		end else if (is_break) begin
			brk_armed <= 1'b0;
		end else if (tick && rxd_i) begin
			brk_armed <= 1'b1;
		end
	end

	// break flag with two-step clear; a new break wins over the clear
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			brk_flag <= 1'b0;
			brk_clr_armed <= 1'b0;
		end else begin
			if (is_break && brk_armed) begin
				brk_flag <= 1'b1;
			end else if (rd_en && dp_addr == OFS_DATA && brk_clr_armed) begin
				brk_flag <= 1'b0;
			end
			if (rd_en && dp_addr == OFS_STATUS2) begin
				brk_clr_armed <= brk_flag;
			end else if (rd_en && dp_addr == OFS_DATA) begin
				brk_clr_armed <= 1'b0;
			end
		end
	end

	// interrupt events; break and reception activity are left out
	always_comb begin
		irq_set = IRQ_RESET;
		irq_set[IRQ_RXFULL_BIT] = char_done;
		irq_set[IRQ_FRAME_BIT] = char_done && stop_low;
		irq_set[IRQ_IDLE_BIT] = idle_hit && idle_armed;
	end

	// sticky status: set beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			irq_stat <= IRQ_RESET;
		end else if (wr_en && dp_addr == OFS_IRQ_CLR) begin
			irq_stat <= (irq_stat & ~hwdata_i[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	// interrupt enable register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			irq_en <= IRQ_RESET;
		end else if (wr_en && dp_addr == OFS_IRQ_EN) begin
			irq_en <= hwdata_i[IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_stat & irq_en);
endmodule

// file: tb/ubsg_chk.sv
// port assertions of the break, status and baud block
`timescale 1ns/1ps
module ubsg_chk
	import ubsg_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic hsel_i, // select
	input wire logic [31:0] haddr_i, // address
	input wire logic [1:0] htrans_i, // type
	input wire logic hwrite_i, // write
	input wire logic [31:0] hwdata_i, // wdata
	input wire logic hready_i, // ready in
	input wire logic [31:0] hrdata_o, // rdata
	input wire logic hreadyout_o, // ready out
	input wire logic tick16_o, // tick
	input wire logic [7:0] tx_data_o, // tx byte
	input wire logic tx_load_o, // tx load
	input wire logic rx_full_set_o, // char in
	input wire logic frame_err_set_o, // bad stop
	input wire logic data_read_o, // data read
	input wire logic irq_o // interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic wr_rate;
	logic [7:0] rate_q;
	logic [7:0] age;
	// rate shadow; age lets the divider counters settle after a change
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wr_rate <= 1'b0;
			rate_q <= RATE_RESET;
			age <= 8'h00;
		end else begin
			wr_rate <= hsel_i && htrans_i[1] && hready_i && hwrite_i && haddr_i[7:0] == OFS_RATE;
			if (wr_rate) begin
				rate_q <= hwdata_i[7:0];
				age <= 8'h00;
			end else if (age != 8'hff) begin
				age <= age + 8'h01;
			end
		end
	end
	sequence s_rd;
		hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	endsequence
	sequence s_wr;
		hsel_i && htrans_i[1] && hready_i && hwrite_i;
	endsequence
	property p_rd_wait;
		s_rd |=> !hreadyout_o ##1 hreadyout_o;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait bad");
	property p_wr_now;
		s_wr |=> hreadyout_o;
	endproperty
	a_wr_now: assert property (p_wr_now) else $error("write wait bad");
	property p_tx_load;
		(s_wr ##0 haddr_i[7:0] == OFS_DATA) |=> ##1 tx_load_o && tx_data_o == $past(hwdata_i[7:0]);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("tx load bad");
	property p_rd_side;
		(s_rd ##0 haddr_i[7:0] == OFS_DATA) |=> ##1 data_read_o;
	endproperty
	a_rd_side: assert property (p_rd_side) else $error("data read pulse bad");
	property p_rst_out;
		$rose(rst_b_i) |-> hrdata_o == WORD_ZERO && !irq_o && !tick16_o;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("reset outputs bad");
	property p_brk;
		frame_err_set_o |-> rx_full_set_o;
	endproperty
	a_brk: assert property (p_brk) else $error("frame error without full");
	property p_tick_bus;
		rate_q == 8'h40 && age == 8'hff |-> tick16_o;
	endproperty
	a_tick_bus: assert property (p_tick_bus) else $error("bus tick bad");
	property p_tick_xtal;
		rate_q == RATE_RESET && age == 8'hff && tick16_o |=> !tick16_o [*3];
	endproperty
	a_tick_xtal: assert property (p_tick_xtal) else $error("xtal tick bad");
endmodule

// file: tb/ubsg_line_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
module ubsg_line_model (
	input wire logic clk_i, // timing reference
	output logic rxd_o // receive line, idle high
);
	int bit_cyc = 16; // clocks per bit, follows the rate in use
	initial rxd_o = 1'b1;
	// plain level; the line keeps it until told otherwise
	task automatic hold(input logic v);
		rxd_o <= v;
	endtask
	// start, data lsb first, stop; the line then stays high
	task automatic frame(input logic [8:0] d, input int nd);
		for (int i = -1; i <= nd; i++) begin
			rxd_o <= (i < 0) ? 1'b0 : (i == nd) ? 1'b1 : d[i];
			repeat (bit_cyc) @(posedge clk_i);
		end
	endtask
endmodule

// file: tb/tb_uart_break_status_baud_gen.sv
// self-checking bench of the break, status and baud block
`timescale 1ns/1ps
module tb_uart_break_status_baud_gen
	import ubsg_pkg::*;
;
	logic clk_i, rst_b_i, hsel_i, hwrite_i, xtal_tick_i, nine_bit_i;
	logic [31:0] haddr_i, hwdata_i, q;
	logic [1:0] htrans_i, xc;
	logic [2:0] hsize_i;
	wire logic hready_i, rxd_i, hreadyout_o, tick16_o, tx_load_o, rx_full_set_o;
	wire logic frame_err_set_o, rx_bit8_o, data_read_o, irq_o, hresp_o;
	wire logic [31:0] hrdata_o;
	wire logic [7:0] tx_data_o;
	int failures, checks_done, n_fe, n, p, r;
	int pd[4] = '{1, 3, 4, 13};
	assign hready_i = hreadyout_o; // single slave
	ubsg_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.rxd_i(rxd_i), .xtal_tick_i(xtal_tick_i), .nine_bit_i(nine_bit_i), .tick16_o(tick16_o),
		.tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .rx_full_set_o(rx_full_set_o),
		.frame_err_set_o(frame_err_set_o), .rx_bit8_o(rx_bit8_o), .data_read_o(data_read_o),
		.irq_o(irq_o));
	ubsg_line_model line_u (.clk_i(clk_i), .rxd_o(rxd_i));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// crystal pulse every fourth clock, so its ticks differ from bus ticks
	always @(posedge clk_i) begin
		xc <= xc + 2'h1;
		xtal_tick_i <= xc == 2'h2;
		if (frame_err_set_o === 1'b1) n_fe++;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// wait for ready or tick, bounded so a hang ends the run
	task automatic wt(input bit t, output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (k > 3000) begin
				failures++;
				tally_and_finish();
			end
		end while ((t ? tick16_o : hreadyout_o) !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		hwrite_i <= w;
		haddr_i <= {24'h000000, a};
		wt(1'b0, n);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		wt(1'b0, n);
		q = hrdata_o;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		bus(1'b0, a, WORD_ZERO);
		chk(nm, q & m, e);
		chk("resp", hresp_o, WORD_ZERO);
	endtask
	task automatic rst;
		rst_b_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
	endtask
	initial begin
		{rst_b_i, hsel_i, hwrite_i, nine_bit_i, xtal_tick_i, htrans_i, xc} = 9'h000;
		{haddr_i, hwdata_i} = 64'h0;
		hsize_i = 3'h2;
		rst();
		rdc("status", OFS_STATUS2, 32'hff, WORD_ZERO);
		rdc("rate", OFS_RATE, 32'hff, WORD_ZERO);
		rdc("hole", 8'h20, 32'hff, WORD_ZERO);
		// crystal source after reset: 4 clocks a tick, 64 a bit
		line_u.bit_cyc = 64;
		line_u.frame(9'h0a5, 8);
		rdc("rx byte", OFS_DATA, 32'hff, 32'ha5);
		bus(1'b1, OFS_DATA, 32'h3c);
		rdc("rx kept", OFS_DATA, 32'hff, 32'ha5);
		chk("tx byte", tx_data_o, 32'h3c);
		rst();
		rdc("after reset", OFS_DATA, 32'hff, 32'ha5);
		chk("tx kept", tx_data_o, 32'h3c);
		// each prescaler code, then each divisor code, from the bus clock
		for (int k = 0; k < 12; k++) begin
			p = (k < 4) ? k : 0;
			r = (k < 4) ? 1 : k - 4;
			bus(1'b1, OFS_RATE, 32'h40 | 32'(p << 4) | 32'(r));
			wt(1'b1, n);
			wt(1'b1, n);
			wt(1'b1, n);
			chk("tick period", 32'(n), 32'(pd[p] << r));
		end
		// spare bits 7 and 3 must not store
		bus(1'b1, OFS_RATE, 32'hff);
		rdc("rate rw", OFS_RATE, 32'hff, 32'h77);
		bus(1'b1, OFS_RATE, 32'h40);
		line_u.bit_cyc = 16;
		line_u.hold(1'b0);
		repeat (2) @(posedge clk_i);
		rdc("active", OFS_STATUS2, 32'h1, 32'h1);
		line_u.hold(1'b1);
		repeat (20) @(posedge clk_i);
		rdc("false start", OFS_STATUS2, 32'h1, WORD_ZERO);
		line_u.frame(9'h0ff, 8);
		repeat (200) @(posedge clk_i);
		rdc("idle", OFS_STATUS2, 32'h1, WORD_ZERO);
		// break with line held low; interrupt raised, masked, cleared
		bus(1'b1, OFS_IRQ_EN, 32'h7);
		line_u.hold(1'b0);
		repeat (170) @(posedge clk_i);
		rdc("break", OFS_STATUS2, 32'h2, 32'h2);
		chk("frame err", 32'(n_fe), 32'h1);
		chk("irq", irq_o, 32'h1);
		bus(1'b1, OFS_IRQ_EN, WORD_ZERO);
		@(posedge clk_i);
		chk("masked", irq_o, WORD_ZERO);
		bus(1'b1, OFS_IRQ_EN, 32'h7);
		bus(1'b1, OFS_IRQ_CLR, 32'h7);
		@(posedge clk_i);
		chk("cleared", irq_o, WORD_ZERO);
		rdc("irq stat", OFS_IRQ_STAT, 32'h7, WORD_ZERO);
		rdc("break kept", OFS_STATUS2, 32'h2, 32'h2);
		bus(1'b0, OFS_DATA, WORD_ZERO);
		rdc("break clr", OFS_STATUS2, 32'h2, WORD_ZERO);
		repeat (200) @(posedge clk_i);
		rdc("no rearm", OFS_STATUS2, 32'h2, WORD_ZERO);
		chk("frame err", 32'(n_fe), 32'h2);
		line_u.hold(1'b1);
		nine_bit_i <= 1'b1;
		// the held-low line restarted a character; let it finish before framing
		repeat (200) @(posedge clk_i);
		line_u.frame(9'h100, 9);
		chk("ninth", rx_bit8_o, 32'h1);
		line_u.hold(1'b0);
		repeat (190) @(posedge clk_i);
		line_u.hold(1'b1);
		rdc("rearmed", OFS_STATUS2, 32'h2, 32'h2);
		chk("ninth clr", rx_bit8_o, WORD_ZERO);
		tally_and_finish();
	end
endmodule
bind ubsg_top ubsg_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .tick16_o(tick16_o),
	.tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .rx_full_set_o(rx_full_set_o),
	.frame_err_set_o(frame_err_set_o), .data_read_o(data_read_o), .irq_o(irq_o));
